//--- rtl/p1fs_pkg.sv
package p1fs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index (low 30 bits kept)
    localparam logic [31:0] FSEL_IDX = 32'hFFFFF462;
    localparam logic [31:0] MODE_IDX = 32'hFFFFF442;
    localparam logic [31:0] FALL_IDX = 32'hFFFFFC02;
    localparam logic [31:0] RISE_IDX = 32'hFFFFFC22;
    localparam logic [31:0] STAT_IDX = 32'hFFFFFD00;
    localparam logic [31:0] MASK_IDX = 32'hFFFFFD01;
    localparam logic [31:0] BITOP_IDX = 32'hFFFFFD02;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [3:0] FSEL_RST = 4'h0;
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [1:0] FALL_RST = 2'h0;
    localparam logic [1:0] RISE_RST = 2'h3;
    localparam logic [1:0] MASK_RST = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // single-bit access word: bit number, target register, new value
    localparam int BITOP_BIT_LSB = 0;
    localparam int BITOP_SEL_LSB = 4;
    localparam int BITOP_VAL_POS = 8;

    // low level is sampled once every four main clock cycles
    localparam logic [1:0] PRESC_LAST = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        P1FS_TRIG_FALL,
        P1FS_TRIG_RISE,
        P1FS_TRIG_LOW,
        P1FS_TRIG_BOTH
    } p1fs_trig_t;

    typedef enum logic [2:0] {
        P1FS_REG_NONE,
        P1FS_REG_FSEL,
        P1FS_REG_MODE,
        P1FS_REG_FALL,
        P1FS_REG_RISE,
        P1FS_REG_STAT,
        P1FS_REG_MASK,
        P1FS_REG_BITOP
    } p1fs_reg_t;

    function automatic p1fs_reg_t reg_decode(input logic [31:0] addr);
        p1fs_reg_t r;
        r = P1FS_REG_NONE;
        if (addr[31:2] == FSEL_IDX[29:0]) r = P1FS_REG_FSEL;
        if (addr[31:2] == MODE_IDX[29:0]) r = P1FS_REG_MODE;
        if (addr[31:2] == FALL_IDX[29:0]) r = P1FS_REG_FALL;
        if (addr[31:2] == RISE_IDX[29:0]) r = P1FS_REG_RISE;
        if (addr[31:2] == STAT_IDX[29:0]) r = P1FS_REG_STAT;
        if (addr[31:2] == MASK_IDX[29:0]) r = P1FS_REG_MASK;
        if (addr[31:2] == BITOP_IDX[29:0]) r = P1FS_REG_BITOP;
        return r;
    endfunction : reg_decode

endpackage : p1fs_pkg

//--- rtl/p1fs_trig_if.sv
`timescale 1ns/1ps
interface p1fs_trig_if;
    logic pin;
    logic sample_stb;
    p1fs_pkg::p1fs_trig_t mode;
    logic event_pulse;

    modport ctrl (
        output pin,
        output sample_stb,
        output mode,
        input event_pulse
    );

    modport det (
        input pin,
        input sample_stb,
        input mode,
        output event_pulse
    );
endinterface : p1fs_trig_if

//--- rtl/p1fs_trig_detect.sv
`timescale 1ns/1ps
module p1fs_trig_detect (
    input wire logic clk_i,
    input wire logic rst_n_i,
    p1fs_trig_if.det tif
);

    typedef struct packed {
        logic prev;
    } p1fs_det_state_t;

    p1fs_det_state_t st;
    p1fs_det_state_t next_st;
    logic fall;
    logic rise;

    assign fall = st.prev & ~tif.pin;
    assign rise = ~st.prev & tif.pin;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_st = st;
        next_st.prev = tif.pin;
        unique case (tif.mode)
            p1fs_pkg::P1FS_TRIG_FALL: tif.event_pulse = fall; // [R8]
            p1fs_pkg::P1FS_TRIG_RISE: tif.event_pulse = rise; // [R8]
            // a pin held low keeps firing on every sample [R13] [R14]
            p1fs_pkg::P1FS_TRIG_LOW: tif.event_pulse = tif.sample_stb & ~tif.pin; // [R8]
            p1fs_pkg::P1FS_TRIG_BOTH: tif.event_pulse = fall | rise; // [R8]
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            st <= '{prev: 1'b1};
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule : p1fs_trig_detect

//--- rtl/p1fs_port1.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// R1 - function select register allows whole-byte or single-bit reads and writes
// R2 - in port mode a pin's function select bit has no effect
// R3 - control mode pin three: 0 sync serial data out, 1 async transmit
// R4 - control mode pin two: 0 feeds sync serial input, 1 async receive
// R5 - control mode pin one: 0 interrupt input, 1 bidirectional serial clock
// R6 - control mode pin zero: 0 interrupt input, 1 usb clock input
// R7 - software sets function bit 0, then mode bit 0, then connects usb clock
// R8 - falling/rising pair: 00 fall, 01 rise, 10 low level, 11 both edges
// R9 - bit 0 serves interrupt input zero, bit 1 interrupt input one
// R10 - both trigger registers allow byte or single-bit reads and writes
// R11 - software programs mode control before the trigger mode
// R12 - changing mode control after trigger setup may raise a spurious request
// R13 - low level sampled every four clocks; each low sample latches the flag
// R14 - flag sets again after acknowledge while pin stays low
// R15 - service routine releases the source, then clears the flag
// R16 - a latched level request stays pending after the pin goes inactive
// R17 - software discards a held request by clearing its flag
// R18 - mode bit 0 selects port, 1 the alternate function chosen by select
module p1fs_port1 (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [3:0] p1_pin_i,
    output logic [3:0] p1_pin_o,
    output logic [3:0] p1_pin_oe_o,
    input wire logic [3:0] port_data_i,
    input wire logic [3:0] port_drive_i,
    input wire logic sync_serial_data_out_i,
    input wire logic async_transmit_out_i,
    input wire logic sync_serial_clock_out_i,
    input wire logic sync_serial_clock_oe_i,
    output logic sync_serial_data_in_o,
    output logic async_receive_in_o,
    output logic sync_serial_clock_in_o,
    output logic usb_clock_input_o,
    input wire logic [1:0] irq_ack_i,
    output logic [1:0] ext_irq_request_flag_o,
    output logic irq_o
);

    typedef struct packed {
        logic [3:0] fsel;
        logic [3:0] mode;
        logic [1:0] fall;
        logic [1:0] rise;
        logic [1:0] flag;
        logic [1:0] mask;
        logic [1:0] presc;
        logic aw_got;
        logic [31:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
        logic ss_din;
        logic as_rx;
        logic ss_clk;
        logic usb_clk;
        logic irq;
    } p1fs_state_t;

    p1fs_state_t st;
    p1fs_state_t next_st;
    logic [1:0] irq_in;
    logic [1:0] ev;
    logic aw_take;
    logic w_take;
    logic ar_take;

    p1fs_trig_if trig[2] ();

    ////////////////////////////////////////////////////////////////////////////
    // writes one bit of a register image, bits past the width are ignored
    function automatic logic [7:0] bit_put(
        input logic [7:0] v,
        input logic [2:0] b,
        input logic val,
        input logic [7:0] width_mask
    );
        logic [7:0] r;
        r = v;
        r[b] = val;
        return r & width_mask;
    endfunction : bit_put

    ////////////////////////////////////////////////////////////////////////////
    // interrupt inputs are forced idle high unless the pin is in control mode
    // with select 0; flipping mode later can fake an edge [R12]
    assign irq_in[0] = (st.mode[0] & ~st.fsel[0]) ? p1_pin_i[0] : 1'b1; // [R2] [R6] [R18]
    assign irq_in[1] = (st.mode[1] & ~st.fsel[1]) ? p1_pin_i[1] : 1'b1; // [R2] [R5] [R18]

    for (genvar g = 0; g < 2; g++)
    begin : g_trig
        assign trig[g].pin = irq_in[g];
        assign trig[g].sample_stb = (st.presc == p1fs_pkg::PRESC_LAST); // [R13]
        assign trig[g].mode = p1fs_pkg::p1fs_trig_t'({st.fall[g], st.rise[g]}); // [R8] [R9]
        assign ev[g] = trig[g].event_pulse;

        p1fs_trig_detect u_det (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .tif(trig[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    assign s_axi_awready_o = ~st.aw_got & ~st.bvalid;
    assign s_axi_wready_o = ~st.w_got & ~st.bvalid;
    assign s_axi_arready_o = ~st.rvalid;
    assign aw_take = s_axi_awvalid_i & s_axi_awready_o;
    assign w_take = s_axi_wvalid_i & s_axi_wready_o;
    assign ar_take = s_axi_arvalid_i & s_axi_arready_o;

    assign s_axi_bvalid_o = st.bvalid;
    assign s_axi_bresp_o = st.bresp;
    assign s_axi_rvalid_o = st.rvalid;
    assign s_axi_rdata_o = st.rdata;
    assign s_axi_rresp_o = st.rresp;
    assign p1_pin_o = st.pin_out;
    assign p1_pin_oe_o = st.pin_oe;
    assign sync_serial_data_in_o = st.ss_din;
    assign async_receive_in_o = st.as_rx;
    assign sync_serial_clock_in_o = st.ss_clk;
    assign usb_clock_input_o = st.usb_clk;
    assign ext_irq_request_flag_o = st.flag;
    assign irq_o = st.irq;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        p1fs_pkg::p1fs_reg_t wsel;
        p1fs_pkg::p1fs_reg_t rsel;
        logic [1:0] clr;
        logic [2:0] bnum;
        logic bval;
        logic [7:0] tmp;
        wsel = p1fs_pkg::reg_decode(st.awaddr);
        rsel = p1fs_pkg::reg_decode(s_axi_araddr_i);
        clr = irq_ack_i;
        bnum = st.wdata[p1fs_pkg::BITOP_BIT_LSB +: 3];
        bval = st.wdata[p1fs_pkg::BITOP_VAL_POS];
        tmp = 8'h00;
        next_st = st;

        next_st.presc = st.presc + 2'h1;

        // write channel: address and data in either order, then one response
        if (aw_take)
        begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr_i;
        end
        if (w_take)
        begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata_i;
            next_st.wstrb = s_axi_wstrb_i;
        end
        if (st.bvalid && s_axi_bready_i)
        begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_got && st.w_got && !st.bvalid)
        begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = (wsel == p1fs_pkg::P1FS_REG_NONE) ? p1fs_pkg::RESP_SLVERR : p1fs_pkg::RESP_OKAY;
            if (st.wstrb[0])
            begin
                unique case (wsel)
                    p1fs_pkg::P1FS_REG_FSEL: next_st.fsel = st.wdata[3:0]; // [R1]
                    p1fs_pkg::P1FS_REG_MODE: next_st.mode = st.wdata[3:0]; // [R18]
                    p1fs_pkg::P1FS_REG_FALL: next_st.fall = st.wdata[1:0]; // [R10]
                    p1fs_pkg::P1FS_REG_RISE: next_st.rise = st.wdata[1:0]; // [R10]
                    p1fs_pkg::P1FS_REG_STAT: clr = clr | st.wdata[1:0]; // [R17]
                    p1fs_pkg::P1FS_REG_MASK: next_st.mask = st.wdata[1:0];
                    p1fs_pkg::P1FS_REG_BITOP:
                    begin
                        // one bit changes, its neighbours keep their value [R1] [R10]
                        unique case (st.wdata[p1fs_pkg::BITOP_SEL_LSB +: 2])
                            2'h0:
                            begin
                                tmp = bit_put({4'h0, st.fsel}, bnum, bval, 8'h0F);
                                next_st.fsel = tmp[3:0];
                            end
                            2'h1:
                            begin
                                tmp = bit_put({4'h0, st.mode}, bnum, bval, 8'h0F);
                                next_st.mode = tmp[3:0];
                            end
                            2'h2:
                            begin
                                tmp = bit_put({6'h00, st.fall}, bnum, bval, 8'h03);
                                next_st.fall = tmp[1:0];
                            end
                            2'h3:
                            begin
                                tmp = bit_put({6'h00, st.rise}, bnum, bval, 8'h03);
                                next_st.rise = tmp[1:0];
                            end
                        endcase
                    end
                    p1fs_pkg::P1FS_REG_NONE:
                    begin
                    end
                endcase
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // read channel
        if (st.rvalid && s_axi_rready_i)
        begin
            next_st.rvalid = 1'b0;
        end
        if (ar_take)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = p1fs_pkg::RESP_OKAY;
            unique case (rsel)
                p1fs_pkg::P1FS_REG_FSEL: next_st.rdata = {28'h0000000, st.fsel}; // [R1]
                p1fs_pkg::P1FS_REG_MODE: next_st.rdata = {28'h0000000, st.mode};
                p1fs_pkg::P1FS_REG_FALL: next_st.rdata = {30'h0, st.fall}; // [R10]
                p1fs_pkg::P1FS_REG_RISE: next_st.rdata = {30'h0, st.rise}; // [R10]
                p1fs_pkg::P1FS_REG_STAT: next_st.rdata = {30'h0, st.flag};
                p1fs_pkg::P1FS_REG_MASK: next_st.rdata = {30'h0, st.mask};
                p1fs_pkg::P1FS_REG_BITOP: next_st.rdata = 32'h00000000;
                p1fs_pkg::P1FS_REG_NONE:
                begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = p1fs_pkg::RESP_SLVERR;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////
        // request flags: a new event wins over acknowledge or software clear,
        // so in low-level mode a pin still low sets the flag again at its next sample, and a latched level holds until cleared
        next_st.flag = (st.flag & ~clr) | ev; // [R13] [R14] [R16]
        next_st.irq = |(next_st.flag & next_st.mask);

        ////////////////////////////////////////////////////////////////////////
        // pin routing; port mode hands the pins to the port logic untouched
        next_st.pin_out = port_data_i;
        next_st.pin_oe = port_drive_i;
        if (st.mode[0])
        begin
            next_st.pin_out[0] = 1'b0; // [R6]
            next_st.pin_oe[0] = 1'b0;
        end
        if (st.mode[1])
        begin
            next_st.pin_out[1] = st.fsel[1] & sync_serial_clock_out_i; // [R5]
            next_st.pin_oe[1] = st.fsel[1] & sync_serial_clock_oe_i; // [R5]
        end
        if (st.mode[2])
        begin
            next_st.pin_out[2] = 1'b0; // [R4]
            next_st.pin_oe[2] = 1'b0;
        end
        if (st.mode[3])
        begin
            next_st.pin_out[3] = st.fsel[3] ? async_transmit_out_i : sync_serial_data_out_i; // [R3]
            next_st.pin_oe[3] = 1'b1;
        end
        // idle-high serial inputs, so a deselected receiver sees a quiet line
        next_st.ss_din = (st.mode[2] & ~st.fsel[2]) ? p1_pin_i[2] : 1'b1; // [R4] [R2]
        next_st.as_rx = (st.mode[2] & st.fsel[2]) ? p1_pin_i[2] : 1'b1; // [R4] [R2]
        next_st.ss_clk = (st.mode[1] & st.fsel[1]) ? p1_pin_i[1] : 1'b1; // [R5]
        // usb clock is passed through a flop, so it must stay well below clk_i
        next_st.usb_clk = st.mode[0] & st.fsel[0] & p1_pin_i[0]; // [R6] [R7]
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            st <= '0;
            st.fsel <= p1fs_pkg::FSEL_RST;
            st.mode <= p1fs_pkg::MODE_RST;
            st.fall <= p1fs_pkg::FALL_RST;
            st.rise <= p1fs_pkg::RISE_RST;
            st.mask <= p1fs_pkg::MASK_RST;
            st.ss_din <= 1'b1;
            st.as_rx <= 1'b1;
            st.ss_clk <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule : p1fs_port1

//--- testbench/p1fs_port1_asserts.sv
`timescale 1ns/1ps
module p1fs_port1_asserts (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [3:0] p1_pin_i,
    input wire logic [3:0] p1_pin_oe_o,
    input wire logic [3:0] port_drive_i,
    input wire logic sync_serial_clock_oe_i,
    input wire logic usb_clock_input_o,
    input wire logic [1:0] ext_irq_request_flag_o,
    input wire logic irq_o
);
    ////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_wr_both;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence s_wr_resp;
        ##[1:2] s_axi_bvalid_o;
    endsequence
    a_write_answer: assert property (s_wr_both |-> s_wr_resp)
        else $error("write response missing");
    a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read data missing");
    a_rdata_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    a_write_refused: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken during response");
    a_irq_level: assert property (irq_o |-> ext_irq_request_flag_o != 2'h0)
        else $error("interrupt without flag");
    // pins zero and two are inputs in control mode, so only port logic may drive them
    a_pin0_drive: assert property (p1_pin_oe_o[0] |-> $past(port_drive_i[0]))
        else $error("pin zero driven");
    a_pin2_drive: assert property (p1_pin_oe_o[2] |-> $past(port_drive_i[2]))
        else $error("pin two driven");
    a_pin1_drive: assert property (p1_pin_oe_o[1] |-> $past(port_drive_i[1] | sync_serial_clock_oe_i))
        else $error("pin one driven");
    a_usb_copy: assert property (usb_clock_input_o |-> $past(p1_pin_i[0]))
        else $error("usb clock not from pin");
    a_flag_cause: assert property ($rose(ext_irq_request_flag_o[0])
        |-> !$past(p1_pin_i[0]) || !$past(p1_pin_i[0], 2) || !$past(p1_pin_i[0], 3))
        else $error("flag set without pin activity");
endmodule : p1fs_port1_asserts
bind p1fs_port1 p1fs_port1_asserts p1fs_port1_asserts_inst (.*);

//--- testbench/p1fs_ext_dev.sv
`timescale 1ns/1ps
module p1fs_ext_dev (
    input wire logic clk_i,
    input wire logic [1:0] irq_lvl_i,
    input wire logic rx_lvl_i,
    input wire logic [3:0] dut_pin_i,
    input wire logic [3:0] dut_oe_i,
    output logic [3:0] pin_o
);
    logic flip = 1'b0;
    always @(posedge clk_i) flip <= ~flip;
    // nothing drives pin three from outside: a toggling level exposes use of an undriven line
    always_comb
    begin
        pin_o[0] = dut_oe_i[0] ? dut_pin_i[0] : irq_lvl_i[0];
        pin_o[1] = dut_oe_i[1] ? dut_pin_i[1] : irq_lvl_i[1];
        pin_o[2] = dut_oe_i[2] ? dut_pin_i[2] : rx_lvl_i;
        pin_o[3] = dut_oe_i[3] ? dut_pin_i[3] : flip;
    end
endmodule : p1fs_ext_dev

//--- testbench/p1fs_port1_tb_top.sv
`timescale 1ns/1ps
module p1fs_port1_tb_top;
    localparam logic [31:0] A_FSEL = {p1fs_pkg::FSEL_IDX[29:0], 2'h0};
    localparam logic [31:0] A_MODE = {p1fs_pkg::MODE_IDX[29:0], 2'h0};
    localparam logic [31:0] A_FALL = {p1fs_pkg::FALL_IDX[29:0], 2'h0};
    localparam logic [31:0] A_RISE = {p1fs_pkg::RISE_IDX[29:0], 2'h0};
    localparam logic [31:0] A_STAT = {p1fs_pkg::STAT_IDX[29:0], 2'h0};
    localparam logic [31:0] A_MASK = {p1fs_pkg::MASK_IDX[29:0], 2'h0};
    localparam logic [31:0] A_BOP = {p1fs_pkg::BITOP_IDX[29:0], 2'h0};
    localparam logic [1:0] OK = p1fs_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = p1fs_pkg::RESP_SLVERR;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [31:0] s_axi_awaddr_i = 32'h0, s_axi_wdata_i = 32'h0, s_axi_araddr_i = 32'h0, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i = 4'hF, port_data_i = 4'h0, port_drive_i = 4'h0;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, ext_irq_request_flag_o, rsp, m0, m1, e1;
    logic [3:0] p1_pin_i, p1_pin_o, p1_pin_oe_o;
    logic sync_serial_data_out_i = 1'b0, async_transmit_out_i = 1'b0;
    logic sync_serial_clock_out_i = 1'b0, sync_serial_clock_oe_i = 1'b0;
    logic sync_serial_data_in_o, async_receive_in_o, sync_serial_clock_in_o, usb_clock_input_o, irq_o;
    logic [1:0] irq_ack_i = 2'h0, ext_lvl = 2'h3;
    logic rx_lvl = 1'b1;
    logic [31:0] rd_v;
    int err_total = 0, compares = 0, cyc_cnt = 0;

    p1fs_port1 p1fs_port1_inst (.*);
    p1fs_ext_dev p1fs_ext_dev_inst (.clk_i(clk_i), .irq_lvl_i(ext_lvl), .rx_lvl_i(rx_lvl),
        .dut_pin_i(p1_pin_o), .dut_oe_i(p1_pin_oe_o), .pin_o(p1_pin_i));

    ////////////////////////////////////////
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end
    function automatic logic [31:0] bop(input int sel, input int b, input logic v);
        return (32'(v) << p1fs_pkg::BITOP_VAL_POS) | (32'(sel) << p1fs_pkg::BITOP_SEL_LSB) | 32'(b);
    endfunction : bop
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    // handshakes are judged at the falling edge so ready, a comb output, is settled
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ha, hw, hb;
        hb = 1'b0;
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        while (!hb)
        begin
            @(negedge clk_i);
            ha = s_axi_awvalid_i & s_axi_awready_o;
            hw = s_axi_wvalid_i & s_axi_wready_o;
            hb = s_axi_bvalid_o & s_axi_bready_i;
            rsp = s_axi_bresp_o;
            @(posedge clk_i);
            if (ha) s_axi_awvalid_i <= 1'b0;
            if (hw) s_axi_wvalid_i <= 1'b0;
            if (hb) s_axi_bready_i <= 1'b0;
        end
        chk("bresp", 32'(er), 32'(rsp));
    endtask : wr
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er, input string nm);
        logic ha, hb;
        hb = 1'b0;
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        while (!hb)
        begin
            @(negedge clk_i);
            ha = s_axi_arvalid_i & s_axi_arready_o;
            hb = s_axi_rvalid_o & s_axi_rready_i;
            rd_v = s_axi_rdata_o;
            rsp = s_axi_rresp_o;
            @(posedge clk_i);
            if (ha) s_axi_arvalid_i <= 1'b0;
            if (hb) s_axi_rready_i <= 1'b0;
        end
        if (nm != "") chk(nm, e, rd_v);
        chk("rresp", 32'(er), 32'(rsp));
    endtask : rd
    task automatic late(input string nm, input logic [31:0] e, input int sel);
        cyc(3);
        @(negedge clk_i);
        if (sel == 0) chk(nm, e, 32'(irq_o));
        if (sel == 1) chk(nm, e, 32'({p1_pin_o[3], p1_pin_oe_o[1], sync_serial_clock_in_o,
            sync_serial_data_in_o, async_receive_in_o, usb_clock_input_o}));
        if (sel == 2) chk(nm, e, 32'({usb_clock_input_o, p1_pin_oe_o, p1_pin_o}));
        if (sel == 3) chk(nm, e, 32'(ext_irq_request_flag_o));
        @(posedge clk_i);
    endtask : late
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        cyc(1);
        rd(A_FSEL, 32'(p1fs_pkg::FSEL_RST), OK, "fsel");
        rd(A_MODE, 32'(p1fs_pkg::MODE_RST), OK, "mode");
        rd(A_FALL, 32'(p1fs_pkg::FALL_RST), OK, "fall");
        rd(A_RISE, 32'(p1fs_pkg::RISE_RST), OK, "rise");
        rd(A_MASK, 32'(p1fs_pkg::MASK_RST), OK, "mask");
        rd(32'h100, 32'h0, ERR, "");
        wr(32'h100, 32'h1, ERR);
        $display("test reset done");
        wr(A_FSEL, 32'hFA, OK);
        rd(A_FSEL, 32'hA, OK, "fsel byte");
        wr(A_BOP, bop(0, 0, 1'b1), OK);
        rd(A_FSEL, 32'hB, OK, "fsel bit");
        wr(A_BOP, bop(3, 0, 1'b0), OK);
        rd(A_RISE, 32'h2, OK, "rise bit");
        wr(A_BOP, bop(2, 1, 1'b1), OK);
        rd(A_FALL, 32'h2, OK, "fall bit");
        wr(A_BOP, bop(1, 3, 1'b1), OK);
        rd(A_MODE, 32'h8, OK, "mode bit");
        rd(A_BOP, 32'h0, OK, "bitop");
        $display("test access done");
        wr(A_MODE, 32'h0, OK);
        wr(A_FSEL, 32'hF, OK);
        port_data_i <= 4'hA;
        port_drive_i <= 4'hF;
        late("port pins", 32'h0FA, 2);
        port_drive_i <= 4'h0;
        sync_serial_data_out_i <= 1'b1;
        sync_serial_clock_oe_i <= 1'b1;
        rx_lvl <= 1'b0;
        ext_lvl <= 2'h2;
        wr(A_MODE, 32'hF, OK);
        late("route alt", 32'h14, 1);
        ext_lvl <= 2'h3;
        late("route usb", 32'h15, 1);
        wr(A_FSEL, 32'h0, OK);
        late("route base", 32'h2A, 1);
        $display("test route done");
        wr(A_MASK, 32'h3, OK);
        for (int m = 0; m < 4; m++)
        begin
            m0 = 2'(m);
            m1 = 2'(m + 1);
            e1 = {m1 != p1fs_pkg::P1FS_TRIG_RISE, m0 != p1fs_pkg::P1FS_TRIG_RISE};
            wr(A_FALL, {30'h0, m1[1], m0[1]}, OK);
            wr(A_RISE, {30'h0, m1[0], m0[0]}, OK);
            wr(A_STAT, 32'h3, OK);
            ext_lvl <= 2'h0;
            cyc(10);
            rd(A_STAT, 32'(e1), OK, "flags low");
            late("irq set", 32'h1, 0);
            ext_lvl <= 2'h3;
            cyc(10);
            rd(A_STAT, 32'h3, OK, "flags high");
            wr(A_STAT, 32'h3, OK);
            rd(A_STAT, 32'h0, OK, "flags clear");
        end
        $display("test trigger done");
        wr(A_FALL, 32'h1, OK);
        wr(A_RISE, 32'h0, OK);
        wr(A_MASK, 32'h1, OK);
        ext_lvl <= 2'h2;
        cyc(8);
        irq_ack_i <= 2'h1;
        cyc(1);
        irq_ack_i <= 2'h0;
        cyc(8);
        rd(A_STAT, 32'h1, OK, "relatch");
        late("flag out", 32'h1, 3);
        late("irq masked in", 32'h1, 0);
        wr(A_MASK, 32'h0, OK);
        late("irq masked out", 32'h0, 0);
        ext_lvl <= 2'h3;
        wr(A_STAT, 32'h1, OK);
        rd(A_STAT, 32'h0, OK, "discard");
        wr(A_MODE, 32'h0, OK);
        wr(A_FALL, 32'h0, OK);
        ext_lvl <= 2'h2;
        wr(A_STAT, 32'h3, OK);
        wr(A_MODE, 32'hF, OK);
        cyc(4);
        rd(A_STAT, 32'h1, OK, "spurious");
        $display("test level done");
        end_of_test();
    end
endmodule : p1fs_port1_tb_top
